// *** pkg/dcbss_pkg.sv ***
package dcbss_pkg;
    localparam int BUS_W   = 16;
    localparam int USED_W  = 12;
    localparam int CYL_W   = 10;
    localparam int SEC_W   = 6;
    localparam int HEAD_W  = 4;
    localparam int UNIT_W  = 3;
    localparam int OFS_W   = 6;
    localparam int LOOK_W  = 4;
    localparam int TAG_W   = 4;

    localparam logic [CYL_W-1:0]  CYL_MAX  = 10'h336;
    localparam logic [HEAD_W-1:0] HEAD_MAX = 4'h8;
    localparam logic [SEC_W-1:0]  SEC_MAX  = 6'h3F;

    localparam int SEC_LSB   = 0;
    localparam int HEAD_LSB  = 8;
    localparam int OFS_LSB   = 0;
    localparam int SIGN_BIT  = 7;
    localparam int CLR_ATTN  = 0;
    localparam int CLR_FIRST = 1;

    localparam int ST_BUSY  = 0;
    localparam int ST_READY = 1;
    localparam int ST_SCHK  = 2;
    localparam int ST_FIRST = 3;
    localparam int ST_FAULT = 4;
    localparam int ST_FMT   = 5;
    localparam int ST_RO    = 6;
    localparam int ST_ATTN  = 7;
    localparam int ST_SCMP  = 8;
    localparam int ST_TYPE  = 9;

    // drive-type code; arbitrary neutral value
    localparam logic [1:0] DRIVE_TYPE = 2'h2;

    localparam logic [TAG_W-1:0] CMD_READ   = 4'h0;
    localparam logic [TAG_W-1:0] CMD_WRITE  = 4'h1;
    localparam logic [TAG_W-1:0] CMD_RQSTAT = 4'h2;
    localparam logic [TAG_W-1:0] CMD_IDENT  = 4'h3;
    localparam logic [TAG_W-1:0] CMD_DISC   = 4'h4;
    localparam logic [TAG_W-1:0] CMD_PRESET = 4'h5;
    localparam logic [TAG_W-1:0] CMD_RQSEC  = 4'h6;
    localparam logic [TAG_W-1:0] CMD_SEEK   = 4'h8;
    localparam logic [TAG_W-1:0] CMD_ADDREC = 4'h9;
    localparam logic [TAG_W-1:0] CMD_UNIT   = 4'hA;
    localparam logic [TAG_W-1:0] CMD_RECAL  = 4'hB;
    localparam logic [TAG_W-1:0] CMD_XMSEC  = 4'hC;
    localparam logic [TAG_W-1:0] CMD_OFFSET = 4'hD;
    localparam logic [TAG_W-1:0] CMD_CLRST  = 4'hE;
endpackage

// *** core/dcbss_sync.sv ***
`timescale 1ns/100ps
module dcbss_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys, // system clock
    input  wire logic         rst,     // async reset, high
    input  wire logic [W-1:0] d,       // asynchronous input
    output logic      [W-1:0] q        // synchronised output
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// *** core/dcbss_top.sv ***
`timescale 1ns/100ps
module dcbss_top (
    input  wire logic                          clk_sys,       // 10 MHz system clock
    input  wire logic                          rst,           // power-on reset, async high
    input  wire logic [dcbss_pkg::TAG_W-1:0]   tag_n,         // tag bus code, active low
    input  wire logic                          strobe_n,      // controller strobe, active low
    input  wire logic [dcbss_pkg::BUS_W-1:0]   cbus_in_n,     // control bus level, active low
    output logic      [dcbss_pkg::BUS_W-1:0]   cbus_out_n,    // control bus drive data, low
    output logic      [dcbss_pkg::BUS_W-1:0]   cbus_oe_n,     // per-line enable, low drives
    input  wire logic [dcbss_pkg::UNIT_W-1:0]  unit_switch,   // unit select switch
    input  wire logic                          run_switch,    // run/stop switch, high = run
    input  wire logic                          format_sw,     // format switch
    input  wire logic                          protect_sw,    // write-protect switch
    input  wire logic                          rpsn_enable,   // look-ahead jumper enable
    input  wire logic [dcbss_pkg::LOOK_W-1:0]  rotational_lookahead, // look-ahead sectors
    input  wire logic                          heads_settled, // servo on cylinder
    input  wire logic                          heads_loaded,  // heads over data area
    input  wire logic                          at_cyl_zero,   // home reached
    input  wire logic                          rw_fault_nd,   // nondestructive r/w fault
    input  wire logic                          hard_fault,    // servo/interlock/destr fault
    input  wire logic [dcbss_pkg::SEC_W-1:0]   present_sector,// sector counter
    input  wire logic                          sector_end,    // end of current sector
    output logic                               select_lamp_n, // unit lamp, active low
    output logic                               rw_enable,     // read/write logic enable
    output logic                               write_allow,   // write not protected
    output logic                               seek_start,    // one-cycle seek request
    output logic                               recal_start,   // one-cycle recalibrate
    output logic      [dcbss_pkg::CYL_W-1:0]   cyl_q,         // new cylinder address
    output logic      [dcbss_pkg::HEAD_W-1:0]  head_q,        // head address
    output logic      [dcbss_pkg::SEC_W-1:0]   sector_q,      // addressed sector
    output logic      [dcbss_pkg::OFS_W-1:0]   offset_mag_q,  // offset magnitude
    output logic                               offset_sign_q  // offset sign
);
    localparam int NIN = dcbss_pkg::TAG_W + 1 + dcbss_pkg::BUS_W + 9;

    logic [NIN-1:0] raw, syn;
    logic [dcbss_pkg::TAG_W-1:0] tag;
    logic [dcbss_pkg::BUS_W-1:0] cbus;
    logic strobe, run_s, fmt_s, ro_s, settled_s, loaded_s, zero_s, ndf_s, hf_s;

    // far-end pins and drive-internal levels both come from outside this clock
    assign raw = {~tag_n, ~strobe_n, ~cbus_in_n, run_switch, format_sw, protect_sw,
                  heads_settled, heads_loaded, at_cyl_zero, rw_fault_nd, hard_fault,
                  sector_end};
    dcbss_sync #(.W(NIN)) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (raw),
        .q       (syn)
    );
    logic secend_s;
    assign {tag, strobe, cbus, run_s, fmt_s, ro_s, settled_s, loaded_s, zero_s, ndf_s, hf_s,
            secend_s} = syn;

    // switches and jumpers are pins as well, so they pass the same two stages
    localparam int NSW = dcbss_pkg::UNIT_W + dcbss_pkg::LOOK_W + 1;
    logic [NSW-1:0]               sw_s;
    logic [dcbss_pkg::UNIT_W-1:0] unit_s;
    logic [dcbss_pkg::LOOK_W-1:0] look_s;
    logic                         rps_en_s;
    dcbss_sync #(.W(NSW)) u_sync_sw (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       ({unit_switch, rotational_lookahead, rpsn_enable}),
        .q       (sw_s)
    );
    assign {unit_s, look_s, rps_en_s} = sw_s;

    logic strobe_q, run_q, loaded_q, zero_q, settled_q;
    logic sel_q, seeking_q, schk_q, attn_q, first_q, ndf_q, scmp_q;
    logic illegal_seek_q;

    logic stb_rise, stb_fall, run_rise;
    assign stb_rise = strobe & ~strobe_q;
    assign stb_fall = ~strobe & strobe_q;
    assign run_rise = run_s & ~run_q;

    function automatic logic is_cmd(input logic [dcbss_pkg::TAG_W-1:0] t,
                                    input logic [dcbss_pkg::TAG_W-1:0] c);
        is_cmd = (t == c);
    endfunction

    // gated decode: selection required except for the four global commands
    logic c_read, c_write, c_rqs, c_ident, c_disc, c_preset, c_rqsec, c_seek;
    logic c_adr, c_unit, c_recal, c_xms, c_ofs, c_clr, any_sel;
    assign any_sel  = strobe & sel_q;
    assign c_read   = any_sel & is_cmd(tag, dcbss_pkg::CMD_READ);
    assign c_write  = any_sel & is_cmd(tag, dcbss_pkg::CMD_WRITE);
    assign c_rqs    = any_sel & is_cmd(tag, dcbss_pkg::CMD_RQSTAT);
    assign c_rqsec  = any_sel & is_cmd(tag, dcbss_pkg::CMD_RQSEC);
    assign c_ident  = strobe & is_cmd(tag, dcbss_pkg::CMD_IDENT);
    assign c_disc   = strobe & is_cmd(tag, dcbss_pkg::CMD_DISC);
    assign c_preset = strobe & is_cmd(tag, dcbss_pkg::CMD_PRESET);
    assign c_unit   = strobe & is_cmd(tag, dcbss_pkg::CMD_UNIT);
    assign c_seek   = any_sel & is_cmd(tag, dcbss_pkg::CMD_SEEK);
    assign c_adr    = any_sel & is_cmd(tag, dcbss_pkg::CMD_ADDREC);
    assign c_recal  = any_sel & is_cmd(tag, dcbss_pkg::CMD_RECAL);
    assign c_xms    = any_sel & is_cmd(tag, dcbss_pkg::CMD_XMSEC);
    assign c_ofs    = any_sel & is_cmd(tag, dcbss_pkg::CMD_OFFSET);
    assign c_clr    = any_sel & is_cmd(tag, dcbss_pkg::CMD_CLRST);

    // supplemental word fields
    logic [dcbss_pkg::CYL_W-1:0]  bus_cyl;
    logic [dcbss_pkg::SEC_W-1:0]  bus_sec;
    logic [dcbss_pkg::HEAD_W-1:0] bus_head;
    logic [dcbss_pkg::UNIT_W-1:0] bus_unit;
    assign bus_cyl  = cbus[dcbss_pkg::CYL_W-1:0];
    assign bus_unit = cbus[dcbss_pkg::UNIT_W-1:0];
    assign bus_sec  = cbus[dcbss_pkg::SEC_LSB +: dcbss_pkg::SEC_W];
    assign bus_head = cbus[dcbss_pkg::HEAD_LSB +: dcbss_pkg::HEAD_W];

    logic cyl_ok, head_ok, sec_ok;
    assign cyl_ok  = bus_cyl <= dcbss_pkg::CYL_MAX;
    assign head_ok = bus_head <= dcbss_pkg::HEAD_MAX;
    assign sec_ok  = bus_sec <= dcbss_pkg::SEC_MAX;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strobe_q  <= 1'b0;
            run_q     <= 1'b0;
            loaded_q  <= 1'b0;
            zero_q    <= 1'b0;
            settled_q <= 1'b0;
        end else begin
            strobe_q  <= strobe;
            run_q     <= run_s;
            loaded_q  <= loaded_s;
            zero_q    <= zero_s;
            settled_q <= settled_s;
        end
    end

    // select flip-flop
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sel_q <= 1'b0;
        end else if (c_preset || c_disc || run_rise) begin
            sel_q <= 1'b0;
        end else if (c_unit) begin
            sel_q <= (bus_unit == unit_s);
        end
    end

    assign select_lamp_n = ~sel_q;
    assign rw_enable     = sel_q;
    assign write_allow   = sel_q & ~ro_s;

    // address registers, sampled once at strobe leading edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cyl_q         <= '0;
            head_q        <= '0;
            sector_q      <= '0;
            offset_mag_q  <= '0;
            offset_sign_q <= 1'b0;
        end else if (c_preset) begin
            head_q   <= '0;
            sector_q <= '0;
        end else if (stb_rise) begin
            if (c_seek && cyl_ok && !seeking_q) begin
                cyl_q <= bus_cyl;
            end
            if (c_recal) begin
                cyl_q <= '0;
            end
            if (c_adr && head_ok) begin
                head_q <= bus_head;
            end
            if ((c_adr || c_xms) && sec_ok) begin
                sector_q <= bus_sec;
            end
            if (c_ofs) begin
                offset_mag_q  <= cbus[dcbss_pkg::OFS_LSB +: dcbss_pkg::OFS_W];
                offset_sign_q <= cbus[dcbss_pkg::SIGN_BIT];
            end
        end
    end

    // seek issue and in-progress tracking
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seek_start  <= 1'b0;
            recal_start <= 1'b0;
            seeking_q   <= 1'b0;
        end else begin
            seek_start  <= stb_rise & c_seek & cyl_ok & ~seeking_q;
            recal_start <= stb_rise & c_recal;
            if (seek_start || recal_start) begin
                seeking_q <= 1'b1;
            end else if (settled_s && !settled_q) begin
                seeking_q <= 1'b0;
            end
        end
    end

    // seek check: set wins over any clear in the same cycle
    logic schk_set, schk_clr;
    assign schk_set = stb_rise & ((c_seek & (~cyl_ok | seeking_q)) | (c_adr & (~head_ok | ~sec_ok))
                                  | (c_xms & ~sec_ok));
    assign schk_clr = (stb_rise & ((c_seek & cyl_ok & ~seeking_q) | (c_adr & head_ok & sec_ok)
                                   | (c_xms & sec_ok))) | c_preset;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            schk_q <= 1'b0;
        end else if (schk_set) begin
            schk_q <= 1'b1;
        end else if (schk_clr) begin
            schk_q <= 1'b0;
        end
    end

    // illegal seek flags attention at strobe trailing edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            illegal_seek_q <= 1'b0;
        end else if (stb_rise) begin
            illegal_seek_q <= c_seek & ~cyl_ok;
        end else if (stb_fall) begin
            illegal_seek_q <= 1'b0;
        end
    end

    logic attn_set, first_set;
    assign attn_set = (zero_s & ~zero_q) | (~loaded_s & loaded_q)
                      | (settled_s & ~settled_q & seeking_q)
                      | (stb_fall & illegal_seek_q);
    assign first_set = loaded_s & ~loaded_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            attn_q <= 1'b0;
        end else if (attn_set) begin
            attn_q <= 1'b1;
        end else if (c_preset || run_rise || (c_clr && cbus[dcbss_pkg::CLR_ATTN])) begin
            attn_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            first_q <= 1'b0;
        end else if (first_set) begin
            first_q <= 1'b1;
        end else if (c_preset || (c_clr && cbus[dcbss_pkg::CLR_FIRST])) begin
            first_q <= 1'b0;
        end
    end

    // nondestructive fault latch; hard faults pass straight through
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ndf_q <= 1'b0;
        end else if (ndf_s) begin
            ndf_q <= 1'b1;
        end else if (c_preset) begin
            ndf_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scmp_q <= 1'b0;
        end else begin
            scmp_q <= (c_read | c_write) & (present_sector == sector_q) & ~secend_s;
        end
    end

    // look-ahead: identity fires when target is within window ahead of present sector
    logic [dcbss_pkg::SEC_W-1:0] ahead;
    logic rps_hit;
    assign ahead   = sector_q - present_sector;
    assign rps_hit = ~rps_en_s |
                     (ahead <= {{(dcbss_pkg::SEC_W-dcbss_pkg::LOOK_W){1'b0}},
                                look_s});

    logic [dcbss_pkg::BUS_W-1:0] status;
    always_comb begin
        status = '0;
        status[dcbss_pkg::ST_BUSY]  = ~settled_s | seeking_q;
        status[dcbss_pkg::ST_READY] = loaded_s;
        status[dcbss_pkg::ST_SCHK]  = schk_q;
        status[dcbss_pkg::ST_FIRST] = first_q;
        status[dcbss_pkg::ST_FAULT] = ndf_q | hf_s;
        status[dcbss_pkg::ST_FMT]   = fmt_s;
        status[dcbss_pkg::ST_RO]    = ro_s;
        status[dcbss_pkg::ST_ATTN]  = attn_q;
        status[dcbss_pkg::ST_SCMP]  = scmp_q;
        status[dcbss_pkg::ST_TYPE +: 2] = dcbss_pkg::DRIVE_TYPE;
    end

    logic [dcbss_pkg::BUS_W-1:0] drv_d, oe_d;
    always_comb begin
        drv_d = '0;
        oe_d  = '0;
        if (c_read || c_write || c_rqs) begin
            drv_d = status;
            oe_d  = {{(dcbss_pkg::BUS_W-dcbss_pkg::USED_W){1'b0}},
                     {dcbss_pkg::USED_W{1'b1}}};
        end else if (c_rqsec) begin
            drv_d[dcbss_pkg::SEC_LSB +: dcbss_pkg::SEC_W]   = present_sector;
            drv_d[dcbss_pkg::HEAD_LSB +: dcbss_pkg::HEAD_W] = head_q;
            oe_d = {{(dcbss_pkg::BUS_W-dcbss_pkg::USED_W){1'b0}}, {dcbss_pkg::USED_W{1'b1}}};
        end else if (c_ident && attn_q && rps_hit) begin
            drv_d[unit_s] = 1'b1;
            oe_d[unit_s]  = 1'b1;
        end
    end

    // registered drive, ground-true on the wire
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cbus_out_n <= '1;
            cbus_oe_n  <= '1;
        end else begin
            cbus_out_n <= ~drv_d;
            cbus_oe_n  <= ~oe_d;
        end
    end

    a_sel_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (c_preset || c_disc) |=> !sel_q) else $error("select survived preset");
    a_sel_match: assert property (@(posedge clk_sys) disable iff (rst)
        (c_unit && !c_preset && !run_rise) |=> (sel_q == ($past(bus_unit) == unit_s)))
        else $error("select mismatch");
    a_lamp_sel: assert property (@(posedge clk_sys) disable iff (rst)
        select_lamp_n == !rw_enable) else $error("lamp not tied to select");
    a_drv_unsel: assert property (@(posedge clk_sys) disable iff (rst)
        (!sel_q && !c_ident) |=> (cbus_oe_n == '1)) else $error("unselected drive");
    a_ident_line: assert property (@(posedge clk_sys) disable iff (rst)
        (c_ident && attn_q && rps_hit && !sel_q) |=> !cbus_oe_n[$past(unit_s)])
        else $error("identity line not pulled");
    a_schk_seek: assert property (@(posedge clk_sys) disable iff (rst)
        (stb_rise && c_seek && !cyl_ok) |=> schk_q ##[1:12] attn_q)
        else $error("illegal seek not flagged");
    a_clr_first: assert property (@(posedge clk_sys) disable iff (rst)
        (c_clr && cbus[dcbss_pkg::CLR_FIRST] && !first_set) |=> !first_q)
        else $error("first status not cleared");
    a_preset_clr: assert property (@(posedge clk_sys) disable iff (rst)
        (c_preset && !schk_set && !attn_set) |=> (!schk_q && !attn_q && head_q == '0))
        else $error("preset left state");
    a_scmp_cmd: assert property (@(posedge clk_sys) disable iff (rst)
        scmp_q |-> $past(c_read || c_write)) else $error("compare outside r/w");
endmodule

// *** verification/dcbss_ctrl_model.sv ***
`timescale 1ns/100ps
module dcbss_ctrl_model (
    input  wire logic        clk_sys,    // system clock
    input  wire logic [15:0] cbus_out_n, // drive data, low
    input  wire logic [15:0] cbus_oe_n,  // drive enables, low drives
    output logic      [3:0]  tag_n,      // tag code, low
    output logic             strobe_n,   // strobe, low
    output logic      [15:0] cbus_in_n   // resolved wire level
);
    logic [15:0] ctl_n = 16'hFFFF;
    // pulled up: a released line rests high, never at its last value
    assign cbus_in_n = ctl_n & (cbus_out_n | cbus_oe_n);
    initial begin
        tag_n = 4'hF;
        strobe_n = 1'b1;
    end
    // word fields already packed by the caller
    task automatic issue(input logic [3:0] c, input logic [15:0] w, output logic [15:0] rsp);
        @(posedge clk_sys);
        #1;
        tag_n = ~c;
        ctl_n = ~w;
        strobe_n = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1 rsp = cbus_in_n;
        @(posedge clk_sys);
        #1;
        strobe_n = 1'b1;
        tag_n = 4'hF;
        ctl_n = 16'hFFFF;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule

// *** verification/dcbss_tb_top.sv ***
`timescale 1ns/100ps
module dcbss_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  tag_n;
    logic        strobe_n, lamp_n, rw_en, wr_ok, osign;
    logic [15:0] cbus_in_n, cbus_out_n, cbus_oe_n, rsp, w;
    logic [2:0]  unit_sw;
    logic        run_sw = 1'b1, fmt, prot, rps_en = 1'b0, settled = 1'b1;
    logic [3:0]  look = 4'h0, head;
    logic [5:0]  psec = 6'h21, sec, omag;
    logic [9:0]  cyl;
    logic [3:0]  rd_cmds [3] = '{dcbss_pkg::CMD_READ, dcbss_pkg::CMD_WRITE, dcbss_pkg::CMD_RQSTAT};
    integer      seed = 32'h616260e0;
    int          fails = 0, comparisons = 0, tn = 0;
    int          m_cyl = 0, m_schk = 0, m_attn = 0;

    initial forever #50 clk_sys = ~clk_sys;

    dcbss_ctrl_model dcbss_ctrl_model_i (.clk_sys(clk_sys), .cbus_out_n(cbus_out_n),
        .cbus_oe_n(cbus_oe_n), .tag_n(tag_n), .strobe_n(strobe_n), .cbus_in_n(cbus_in_n));
    // static fault and home inputs tied: their logic is checked neither here nor by the assertions
    dcbss_top dcbss_top_i (.clk_sys(clk_sys), .rst(rst), .tag_n(tag_n), .strobe_n(strobe_n),
        .cbus_in_n(cbus_in_n), .cbus_out_n(cbus_out_n), .cbus_oe_n(cbus_oe_n),
        .unit_switch(unit_sw), .run_switch(run_sw), .format_sw(fmt), .protect_sw(prot),
        .rpsn_enable(rps_en), .rotational_lookahead(look), .heads_settled(settled),
        .heads_loaded(1'b1), .at_cyl_zero(1'b0), .rw_fault_nd(1'b0), .hard_fault(1'b0),
        .present_sector(psec), .sector_end(1'b0), .select_lamp_n(lamp_n), .rw_enable(rw_en),
        .write_allow(wr_ok), .seek_start(), .recal_start(), .cyl_q(cyl), .head_q(head),
        .sector_q(sec), .offset_mag_q(omag), .offset_sign_q(osign));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [3:0] c, input logic [15:0] wd);
        dcbss_ctrl_model_i.issue(c, wd, rsp);
    endtask
    task automatic done();
        tn++;
        $display("test %0d ended", tn);
    endtask
    // first status depends on head-load history, so it is masked along with fault
    task automatic stat(input logic [3:0] c);
        logic [11:0] e;
        e = {1'b0, dcbss_pkg::DRIVE_TYPE, 1'b0, m_attn[0], prot, fmt, 2'b00, m_schk[0],
             1'b1, ~settled};
        cmd(c, 16'h0);
        check({rsp[15:12], ~rsp[11:0] & 12'h7E7}, {4'hF, e});
    endtask
    task automatic seek(input int c);
        cmd(dcbss_pkg::CMD_SEEK, 16'(c));
        m_schk = (c > 822);
        m_attn = 1;
        if (c <= 822) begin
            m_cyl = c;
            #1 settled = 1'b0;
            repeat (3) @(posedge clk_sys);
            #1 settled = 1'b1;
            repeat (4) @(posedge clk_sys);
        end
        check(16'(cyl), 16'(m_cyl));
        stat(dcbss_pkg::CMD_RQSTAT);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        fails++;
        conclude();
    end

    initial begin
        unit_sw = 3'($random(seed));
        fmt = 1'($random(seed));
        prot = 1'($random(seed));
        repeat (5) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        check(cbus_oe_n, 16'hFFFF);
        check({15'h0, lamp_n}, 16'h1);
        cmd(dcbss_pkg::CMD_RQSTAT, 16'h0);
        check(rsp, 16'hFFFF);
        cmd(dcbss_pkg::CMD_UNIT, {13'h0, unit_sw ^ 3'h1});
        check({15'h0, lamp_n}, 16'h1);
        cmd(dcbss_pkg::CMD_UNIT, {13'h0, unit_sw});
        check({13'h0, lamp_n, rw_en, wr_ok}, {13'h0, 2'b01, ~prot});
        foreach (rd_cmds[i]) stat(rd_cmds[i]);
        done();
        seek({$random(seed)} % 823);
        seek(823);
        cmd(dcbss_pkg::CMD_CLRST, 16'h3);
        m_attn = 0;
        stat(dcbss_pkg::CMD_RQSTAT);
        done();
        cmd(dcbss_pkg::CMD_ADDREC, 16'h0905);
        check({12'h0, head}, 16'h0);
        cmd(dcbss_pkg::CMD_ADDREC, 16'h083F);
        m_schk = 0;
        check({6'h0, head, sec}, 16'h023F);
        stat(dcbss_pkg::CMD_RQSTAT);
        cmd(dcbss_pkg::CMD_XMSEC, 16'h0312);
        check({6'h0, head, sec}, 16'h0212);
        w = 16'($random(seed)) & 16'h00BF;
        cmd(dcbss_pkg::CMD_OFFSET, w);
        check({9'h0, osign, omag}, {9'h0, w[7], w[5:0]});
        done();
        seek(823);
        cmd(dcbss_pkg::CMD_DISC, 16'h0);
        check({15'h0, lamp_n}, 16'h1);
        #1;
        rps_en = 1'b1;
        look = 4'($random(seed));
        psec = 6'h12;
        cmd(dcbss_pkg::CMD_IDENT, 16'h0);
        check(rsp, ~(16'h1 << unit_sw));
        cmd(dcbss_pkg::CMD_PRESET, 16'h0);
        check({6'h0, head, sec}, 16'h0);
        m_schk = 0;
        m_attn = 0;
        cmd(dcbss_pkg::CMD_UNIT, {13'h0, unit_sw});
        stat(dcbss_pkg::CMD_RQSTAT);
        cmd(dcbss_pkg::CMD_RECAL, 16'h0);
        m_cyl = 0;
        m_attn = 1;
        #1 settled = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 settled = 1'b1;
        repeat (4) @(posedge clk_sys);
        check(16'(cyl), 16'(m_cyl));
        stat(dcbss_pkg::CMD_RQSTAT);
        #1 run_sw = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 run_sw = 1'b1;
        repeat (5) @(posedge clk_sys);
        check({15'h0, lamp_n}, 16'h1);
        done();
        conclude();
    end
endmodule
